// file: design/pcsc_map.svh
// constants of the clock synthesis control block: offsets, fields, resets, timing
// assumes inclusion by bare name from the design modules
// Behaviour
// - oscillator tick runs at a chosen 10, 20, 40 or 80 MHz nominal rate
// - oscillator can be enabled or disabled; disabled means no clock activity
// - eight independent synthesis loops, each deriving clocks from its reference
// - two-bit select picks one of four references for each loop
// - active-low loop reset resets while low; user holds it at least 10 ns
// - output = ref * M * Cfbk / (N * C); post-divider divides the loop frequency
// - lock rises on achieving lock and falls on any detected loss of lock
// - lock is asynchronous with short pulses; monitors must synchronise it
// - output zero only for clocks at most an integer four times the reference
// - three-bit phase value delays outputs half a loop cycle per step
// - five-bit output select chooses the outputs a phase update affects
// - while apply strobe is high, selected outputs take the current phase value
`ifndef PCSC_MAP_SVH
`define PCSC_MAP_SVH

`define PCSC_NUM_LOOPS 8
`define PCSC_NUM_OUTS 5
`define PCSC_NUM_REFS 4

`define PCSC_OFF_OSC_CTRL 8'h00
`define PCSC_OFF_LOCK_STAT 8'h04
`define PCSC_OFF_INT_STAT 8'h08
`define PCSC_OFF_INT_MASK 8'h0C
`define PCSC_OFF_LOOP_BASE 8'h10
`define PCSC_OFF_LOOP_LAST 8'h8C
`define PCSC_LOOP_SHIFT 3
`define PCSC_DIV_BIT 2

`define PCSC_OSC_EN_BIT 0
`define PCSC_OSC_SEL_LSB 1
`define PCSC_OSC_CTRL_RST 3'h0
`define PCSC_INT_RISE_LSB 0
`define PCSC_INT_LOSS_LSB 8
`define PCSC_INT_CFG_LSB 16
`define PCSC_ST_CFG_LSB 8
`define PCSC_ST_OSC_BIT 16
`define PCSC_LOOP_CFG_RST 32'h01010101
`define PCSC_LOOP_DIV_RST 32'h01041041

`define PCSC_PCLK_MHZ 8'h7D
`define PCSC_OSC_F0_MHZ 8'h0A
`define PCSC_OSC_F1_MHZ 8'h14
`define PCSC_OSC_F2_MHZ 8'h28
`define PCSC_OSC_F3_MHZ 8'h50
`define PCSC_PCLK_PERIOD_NS 8
`define PCSC_LOOP_RST_MIN_NS 10
`define PCSC_LOOP_RST_MIN_CYC ((`PCSC_LOOP_RST_MIN_NS + `PCSC_PCLK_PERIOD_NS - 1) / `PCSC_PCLK_PERIOD_NS)
`define PCSC_LOCK_EDGES 16
`define PCSC_OUT0_MAX_RATIO 16'h0004
`define PCSC_MOC_MAX 24'h0000FF

`endif

// file: design/pcsc_pkg.sv
// types shared by the clock synthesis control block
// assumes pcsc_map.svh for the numeric constants
package pcsc_pkg;
    typedef struct packed {
        logic [7:0] cfbk;
        logic [7:0] o;
        logic [7:0] m;
        logic [7:0] n;
    } pcsc_cfg_t;

    typedef enum logic [1:0] {FB_LOCAL, FB_CORE, FB_PAD} pcsc_fb_t;

    typedef struct packed {
        pcsc_fb_t fb_mode;
        logic [4:0][5:0] c;
    } pcsc_div_t;

    typedef struct packed {
        logic apply;
        logic [4:0] sel;
        logic [2:0] shift;
    } pcsc_phase_t;

    typedef enum logic [1:0] {ST_RESET, ST_ACQUIRE, ST_LOCKED} pcsc_state_t;
endpackage : pcsc_pkg

// file: design/pcsc_loop.sv
// one frequency synthesis loop, modelled in the pclk domain
// assumes the selected reference and feedback are sampled levels synchronous to pclk
`timescale 1ns/1ps
`include "pcsc_map.svh"
module pcsc_loop import pcsc_pkg::*; #(
    parameter int LOCK_EDGES = `PCSC_LOCK_EDGES,
    parameter int PER_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ref_in,
    input wire logic fb_in,
    input wire logic loop_reset_n,
    input wire pcsc_cfg_t cfg,
    input wire pcsc_div_t div,
    input wire pcsc_phase_t phase,
    output logic locked,
    output logic [4:0] outs,
    output logic cfg_err
);
    logic ref_q, fb_q, fb_seen;
    logic [PER_W-1:0] cnt, per;
    logic [7:0] good;
    logic [1:0] rst_cnt;
    logic [24:0] acc;
    pcsc_state_t state, next_state;
    logic [4:0] c_nz;

    wire ref_rise = ref_in & ~ref_q;
    wire fb_rise = fb_in & ~fb_q;
    wire [PER_W-1:0] diff = (cnt > per) ? cnt - per : per - cnt;
    wire stable = diff <= PER_W'(1);
    wire ref_lost = &cnt;
    wire [23:0] moc = 24'(cfg.m) * 24'(cfg.o) * 24'(cfg.cfbk);
    wire cfg_ok = (cfg.n != 8'h00) && (moc != 24'h000000) && (moc <= `PCSC_MOC_MAX) && (&c_nz);
    wire [15:0] mult = 16'(cfg.m) * 16'(cfg.cfbk);
    wire [15:0] lim0 = `PCSC_OUT0_MAX_RATIO * 16'(cfg.n) * 16'(div.c[0]);
    wire over0 = mult > lim0;
    wire fb_ok = (div.fb_mode == FB_LOCAL) || fb_seen;
    wire [24:0] step = {8'h00, mult, 1'b0};
    wire [24:0] thr = 25'(per) * 25'(cfg.n);
    wire [24:0] sum = acc + step;
    // at most one half-period per pclk: loop rates above pclk/2 are not modelled
    wire half_tick = (state == ST_LOCKED) && (sum >= thr);

    always_comb begin
        case (state)
            ST_RESET: next_state = (rst_cnt >= 2'(`PCSC_LOOP_RST_MIN_CYC)) ? ST_ACQUIRE : ST_RESET;
            ST_ACQUIRE: next_state = (good == 8'(LOCK_EDGES)) ? ST_LOCKED : ST_ACQUIRE;
            ST_LOCKED: next_state = ((ref_rise && !stable) || ref_lost || !cfg_ok) ? ST_ACQUIRE
                                                                                 : ST_LOCKED;
            default: next_state = ST_RESET;
        endcase
        if (!loop_reset_n) begin
            next_state = ST_RESET;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_RESET;
            rst_cnt <= 2'(`PCSC_LOOP_RST_MIN_CYC);
            locked <= 1'b0;
            cfg_err <= 1'b0;
        end else begin
            state <= next_state;
            if (!loop_reset_n) begin
                rst_cnt <= (rst_cnt == 2'h3) ? rst_cnt : rst_cnt + 2'h1;
            end else if (state != ST_RESET) begin
                rst_cnt <= 2'h0;
            end
            locked <= (next_state == ST_LOCKED);
            cfg_err <= !cfg_ok || over0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_q <= 1'b0;
            fb_q <= 1'b0;
            fb_seen <= 1'b0;
            cnt <= '0;
            per <= '0;
            good <= 8'h00;
            acc <= '0;
        end else begin
            ref_q <= ref_in;
            fb_q <= fb_in;
            fb_seen <= fb_rise | (fb_seen & ~ref_rise);
            if (ref_rise) begin
                per <= cnt;
                cnt <= PER_W'(1);
            end else if (!ref_lost) begin
                cnt <= cnt + PER_W'(1);
            end
            // a wandering reference restarts the count, so lock waits for stability
            if (state != ST_ACQUIRE) begin
                good <= 8'h00;
            end else if (ref_rise) begin
                good <= (stable && cfg_ok && fb_ok) ? good + 8'h01 : 8'h00;
            end
            acc <= (state != ST_LOCKED) ? '0 : (half_tick ? sum - thr : sum);
        end
    end

    for (genvar i = 0; i < `PCSC_NUM_OUTS; i++) begin : gen_out
        logic [5:0] ccnt;
        logic [2:0] cur, skip;
        logic o;
        assign c_nz[i] = |div.c[i];
        assign outs[i] = o;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ccnt <= 6'h00;
                cur <= 3'h0;
                skip <= 3'h0;
                o <= 1'b0;
            end else if (state != ST_LOCKED || (i == 0 && over0)) begin
                ccnt <= 6'h00;
                skip <= 3'h0;
                o <= 1'b0;
            end else if (phase.apply && phase.sel[i]) begin
                cur <= phase.shift;
                skip <= phase.shift - cur;
            end else if (half_tick) begin
                if (skip != 3'h0) begin
                    skip <= skip - 3'h1;
                end else if (ccnt >= div.c[i] - 6'h01) begin
                    ccnt <= 6'h00;
                    o <= ~o;
                end else begin
                    ccnt <= ccnt + 6'h01;
                end
            end
        end
    end

    a_lock_in_reset: assert property (@(posedge pclk) disable iff (!presetn)
        !loop_reset_n |=> !locked) else $error("lock high during loop reset");
    a_lock_after_edges: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(locked) |-> $past(good) == 8'(LOCK_EDGES)) else $error("lock rose early");
    a_lock_loss_drop: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_LOCKED && ref_rise && !stable) |=> !locked)
        else $error("lock kept after loss");
    a_out0_limit: assert property (@(posedge pclk) disable iff (!presetn)
        over0 |=> !outs[0]) else $error("output zero ran above ratio");
    a_outs_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !locked ##1 !locked |-> outs == 5'h00) else $error("outputs toggle unlocked");
    a_phase_load: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_LOCKED && !over0 && phase.apply && phase.sel[1] && loop_reset_n)
        |=> gen_out[1].cur == $past(phase.shift)) else $error("phase not applied");
    c_lock_reached: cover property (@(posedge pclk) disable iff (!presetn) $rose(locked));
    c_lock_lost: cover property (@(posedge pclk) disable iff (!presetn) $fell(locked));
    c_phase_step: cover property (@(posedge pclk) disable iff (!presetn)
        locked && phase.apply && phase.shift == 3'h7);
endmodule : pcsc_loop

// file: design/pcsc_top.sv
// clock synthesis control: low-power oscillator, eight synthesis loops, APB registers
// assumes one pclk at 125 MHz; reference and feedback inputs are sampled on pclk
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "pcsc_map.svh"
module pcsc_top import pcsc_pkg::*; #(
    parameter int LOCK_EDGES = `PCSC_LOCK_EDGES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0][3:0] ref_clock_inputs,
    input wire logic [7:0][1:0] ref_source_select,
    input wire logic [7:0] loop_reset_n,
    input wire logic [7:0] core_feedback_in,
    input wire logic [7:0] pad_feedback_in,
    input wire pcsc_phase_t [7:0] phase_ctrl,
    output logic [7:0][4:0] synth_out,
    output logic [7:0] loop_locked,
    output logic osc_tick,
    output logic irq
);
    localparam int NL = `PCSC_NUM_LOOPS;

    logic [2:0] osc_ctrl;
    logic [7:0] osc_acc;
    logic [23:0] int_stat, int_mask;
    pcsc_cfg_t [NL-1:0] loop_cfg;
    pcsc_div_t [NL-1:0] loop_div;
    logic [NL-1:0][1:0] sel_held;
    logic [NL-1:0] lock_raw, cfg_err, cfg_err_q;
    logic [NL-1:0] lock_s1, lock_s2, lock_s3;
    logic osc_running;

    // bus decode
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pready && pwrite;
    wire aligned = paddr[1:0] == 2'h0;
    wire in_loops = (paddr >= `PCSC_OFF_LOOP_BASE) && (paddr <= `PCSC_OFF_LOOP_LAST);
    wire [7:0] loop_off = paddr - `PCSC_OFF_LOOP_BASE;
    wire [2:0] loop_idx = loop_off[`PCSC_LOOP_SHIFT +: 3];
    wire is_div = paddr[`PCSC_DIV_BIT];
    wire hit_osc = aligned && paddr == `PCSC_OFF_OSC_CTRL;
    wire hit_lock = aligned && paddr == `PCSC_OFF_LOCK_STAT;
    wire hit_ist = aligned && paddr == `PCSC_OFF_INT_STAT;
    wire hit_imask = aligned && paddr == `PCSC_OFF_INT_MASK;
    wire hit_loop = aligned && in_loops;
    wire mapped = hit_osc || hit_lock || hit_ist || hit_imask || hit_loop;
    wire [31:0] bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [31:0] loop_rd = is_div ? 32'(loop_div[loop_idx]) : 32'(loop_cfg[loop_idx]);
    wire [31:0] lock_rd = {15'h0000, osc_running, cfg_err, lock_s2};
    wire [31:0] rd_mux = hit_osc ? {29'h00000000, osc_ctrl} :
                         hit_lock ? lock_rd :
                         hit_ist ? {8'h00, int_stat} :
                         hit_imask ? {8'h00, int_mask} :
                         hit_loop ? loop_rd : 32'h00000000;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask,
                                          input logic [31:0] data);
        merge = (old & ~mask) | (data & mask);
    endfunction : merge

    wire [31:0] osc_new = merge({29'h00000000, osc_ctrl}, bmask, pwdata);
    wire [31:0] mask_new = merge({8'h00, int_mask}, bmask, pwdata);
    wire [31:0] cfg_new = merge(32'(loop_cfg[loop_idx]), bmask, pwdata);
    wire [31:0] div_new = merge(32'(loop_div[loop_idx]), bmask, pwdata);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : rd_mux;
                pslverr <= !mapped;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_ctrl <= `PCSC_OSC_CTRL_RST;
            int_mask <= 24'h000000;
            loop_cfg <= {NL{`PCSC_LOOP_CFG_RST}};
            loop_div <= {NL{`PCSC_LOOP_DIV_RST}};
        end else if (wr_en) begin
            if (hit_osc) begin
                osc_ctrl <= osc_new[2:0];
            end
            if (hit_imask) begin
                int_mask <= mask_new[23:0];
            end
            if (hit_loop && !is_div) begin
                loop_cfg[loop_idx] <= pcsc_cfg_t'(cfg_new);
            end
            if (hit_loop && is_div) begin
                loop_div[loop_idx] <= pcsc_div_t'(div_new);
            end
        end
    end

    // oscillator: fractional accumulator gives a tick per nominal period
    wire osc_en = osc_ctrl[`PCSC_OSC_EN_BIT];
    wire [1:0] osc_sel = osc_ctrl[`PCSC_OSC_SEL_LSB +: 2];
    wire [7:0] osc_inc = (osc_sel == 2'h0) ? `PCSC_OSC_F0_MHZ :
                         (osc_sel == 2'h1) ? `PCSC_OSC_F1_MHZ :
                         (osc_sel == 2'h2) ? `PCSC_OSC_F2_MHZ : `PCSC_OSC_F3_MHZ;
    wire [7:0] osc_sum = osc_acc + osc_inc;
    wire osc_wrap = osc_sum >= `PCSC_PCLK_MHZ;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_acc <= 8'h00;
            osc_tick <= 1'b0;
            osc_running <= 1'b0;
        end else begin
            osc_running <= osc_en;
            osc_tick <= osc_en && osc_wrap;
            osc_acc <= !osc_en ? 8'h00 : (osc_wrap ? osc_sum - `PCSC_PCLK_MHZ : osc_sum);
        end
    end

    for (genvar k = 0; k < NL; k++) begin : gen_loop
        // select moves only while the loop is held in reset, so no runt reference
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sel_held[k] <= 2'h0;
            end else if (!loop_reset_n[k]) begin
                sel_held[k] <= ref_source_select[k];
            end
        end
        wire fb_pick = (loop_div[k].fb_mode == FB_CORE) ? core_feedback_in[k]
                                                        : pad_feedback_in[k];
        pcsc_loop #(
            .LOCK_EDGES(LOCK_EDGES)
        ) u_loop (
            .pclk(pclk),
            .presetn(presetn),
            .ref_in(ref_clock_inputs[k][sel_held[k]]),
            .fb_in(fb_pick),
            .loop_reset_n(loop_reset_n[k]),
            .cfg(loop_cfg[k]),
            .div(loop_div[k]),
            .phase(phase_ctrl[k]),
            .locked(lock_raw[k]),
            .outs(synth_out[k]),
            .cfg_err(cfg_err[k])
        );
    end
    assign loop_locked = lock_raw;

    // lock is treated as asynchronous: two flops before any edge detection
    wire [NL-1:0] lock_rise = lock_s2 & ~lock_s3;
    wire [NL-1:0] lock_loss = ~lock_s2 & lock_s3;
    wire [NL-1:0] cfg_rise = cfg_err & ~cfg_err_q;
    wire [23:0] int_set = {cfg_rise, lock_loss, lock_rise};
    wire [23:0] int_clr = (wr_en && hit_ist) ? pwdata[23:0] & bmask[23:0] : 24'h000000;
    // irq follows a mask write in the same edge, so it never lags the mask
    wire [23:0] next_int_mask = (wr_en && hit_imask) ? mask_new[23:0] : int_mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_s1 <= '0;
            lock_s2 <= '0;
            lock_s3 <= '0;
            cfg_err_q <= '0;
            int_stat <= 24'h000000;
            irq <= 1'b0;
        end else begin
            lock_s1 <= lock_raw;
            lock_s2 <= lock_s1;
            lock_s3 <= lock_s2;
            cfg_err_q <= cfg_err;
            // a new event beats a same-cycle clear
            int_stat <= (int_stat & ~int_clr) | int_set;
            irq <= |(((int_stat & ~int_clr) | int_set) & next_int_mask);
        end
    end

    a_osc_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !osc_en |=> !osc_tick) else $error("oscillator ticks while disabled");
    a_lock_event_set: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(lock_raw[0]) |-> ##3 int_stat[`PCSC_INT_RISE_LSB])
        else $error("lock rise not recorded");
    a_sel_held_run: assert property (@(posedge pclk) disable iff (!presetn)
        loop_reset_n[0] ##1 loop_reset_n[0] |-> $stable(sel_held[0]))
        else $error("reference changed while running");
    a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        (int_stat[`PCSC_INT_LOSS_LSB] && int_mask[`PCSC_INT_LOSS_LSB]) |-> irq)
        else $error("masked-in event without interrupt");
    c_osc_tick_fast: cover property (@(posedge pclk) disable iff (!presetn)
        osc_tick && osc_sel == 2'h3);
endmodule : pcsc_top

// file: verif/pcsc_user_model.sv
// fabric-side partner: reference sources and feedback wiring for all loops
// assumes pclk-sampled levels; reference 2 of every loop is a stopped source
`timescale 1ns/1ps
module pcsc_user_model import pcsc_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0][4:0] synth_out,
    output logic [7:0][3:0] ref_clock_inputs,
    output logic [7:0] core_feedback_in,
    output logic [7:0] pad_feedback_in
);
    logic [7:0] ref_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ref_cnt <= 8'h00;
        else ref_cnt <= ref_cnt + 8'h01;
    end
    // sources run from reset so they are stable before any loop release
    // no loop feeds another, so no cascade chain exists
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            ref_clock_inputs[k] = {ref_cnt[2], 1'b0, ref_cnt[3], ref_cnt[2]};
            core_feedback_in[k] = synth_out[k][1];
            pad_feedback_in[k] = synth_out[k][1];
        end
    end
endmodule : pcsc_user_model

// file: verif/pcsc_top_bench.sv
// self-checking bench: APB register rows, loop lock, phase, interrupt, oscillator
// assumes pcsc_top with a short lock count and the fabric partner model
`timescale 1ns/1ps
module pcsc_top_bench import pcsc_pkg::*; ;
    typedef struct packed {
        logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] rd; logic er;
    } pcsc_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_tick, irq;
    logic [7:0] paddr, loop_reset_n, core_feedback_in, pad_feedback_in, loop_locked;
    logic [31:0] pwdata, prdata, rdv;
    logic [3:0] pstrb;
    logic erv;
    logic [7:0][3:0] ref_clock_inputs;
    logic [7:0][1:0] ref_source_select;
    pcsc_phase_t [7:0] phase_ctrl;
    logic [7:0][4:0] synth_out;
    int err_total, checked, cnt[5], ticks;
    pcsc_row_t rows[11];
    pcsc_top #(.LOCK_EDGES(2)) pcsc_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ref_clock_inputs(ref_clock_inputs), .ref_source_select(ref_source_select),
        .loop_reset_n(loop_reset_n), .core_feedback_in(core_feedback_in),
        .pad_feedback_in(pad_feedback_in), .phase_ctrl(phase_ctrl), .synth_out(synth_out),
        .loop_locked(loop_locked), .osc_tick(osc_tick), .irq(irq));
    pcsc_user_model pcsc_user_model_inst (.pclk(pclk), .presetn(presetn),
        .synth_out(synth_out), .ref_clock_inputs(ref_clock_inputs),
        .core_feedback_in(core_feedback_in), .pad_feedback_in(pad_feedback_in));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task print_verdict();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) err_total++;
    endtask : apb
    task count_outs(input int cyc);
        logic [4:0] prev;
        prev = synth_out[0];
        cnt = '{0, 0, 0, 0, 0};
        repeat (cyc) begin
            @(posedge pclk);
            for (int i = 0; i < 5; i++) if (synth_out[0][i] !== prev[i]) cnt[i]++;
            prev = synth_out[0];
        end
    endtask : count_outs
    task count_ticks(input int cyc);
        ticks = 0;
        repeat (cyc) begin
            @(posedge pclk);
            if (osc_tick === 1'b1) ticks++;
        end
    endtask : count_ticks
    task wait_lock(input logic [7:0] m);
        int n;
        n = 0;
        while ((loop_locked & m) !== m && n < 200) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_lock
    initial begin
        #480000;
        err_total++;
        print_verdict();
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; pstrb = 4'hF; loop_reset_n = 8'h00; ref_source_select = '0;
        phase_ctrl = '0; err_total = 0; checked = 0;
        rows = '{
            '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
            '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h10, 32'h0, 32'h01010101, 1'b0},
            '{1'b0, 8'h14, 32'h0, 32'h01041041, 1'b0}, '{1'b0, 8'h8C, 32'h0, 32'h01041041, 1'b0},
            '{1'b0, 8'h90, 32'h0, 32'h0, 1'b1}, '{1'b0, 8'h02, 32'h0, 32'h0, 1'b1},
            '{1'b1, 8'h04, 32'hFFFF, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
            '{1'b1, 8'h90, 32'h5, 32'h0, 1'b1}};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            check({erv, 31'h0}, {rows[i].er, 31'h0});
            if (!rows[i].wr) check(rdv, rows[i].rd);
        end
        $display("test registers done");
        // output two of loop 0 divided by two, set before release
        apb(1'b1, 8'h14, 32'h01042041);
        apb(1'b1, 8'h0C, 32'h00000101);
        repeat (2) @(posedge pclk);
        loop_reset_n <= 8'hFF;
        wait_lock(8'hFF);
        check(loop_locked, 8'hFF);
        repeat (6) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0);
        check(rdv, 32'h000000FF);
        apb(1'b0, 8'h08, 32'h0);
        check(rdv, 32'h000000FF);
        check(irq, 1'b1);
        $display("test lock done");
        count_outs(400);
        check(cnt[1] >= 95 && cnt[1] <= 105, 1'b1);
        check(cnt[1] >= 2 * cnt[2] - 2 && cnt[1] <= 2 * cnt[2] + 2, 1'b1);
        check(cnt[0] > 0, 1'b1);
        phase_ctrl[0] <= '{apply: 1'b1, sel: 5'h02, shift: 3'h4};
        @(posedge pclk);
        phase_ctrl[0] <= '0;
        count_outs(400);
        check(cnt[3] - cnt[1] >= 3 && cnt[3] - cnt[1] <= 5, 1'b1);
        check(cnt[4], cnt[3]);
        $display("test outputs done");
        apb(1'b1, 8'h08, 32'h000000FF);
        repeat (2) @(posedge pclk);
        check(irq, 1'b0);
        loop_reset_n[0] <= 1'b0;
        repeat (3) @(posedge pclk);
        check(loop_locked[0], 1'b0);
        check(synth_out[0], 5'h00);
        repeat (6) @(posedge pclk);
        check(irq, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        check(rdv, 32'h00000100);
        $display("test interrupt done");
        ref_source_select[0] <= 2'h2;
        repeat (3) @(posedge pclk);
        loop_reset_n[0] <= 1'b1;
        repeat (200) @(posedge pclk);
        check(loop_locked[0], 1'b0);
        loop_reset_n[0] <= 1'b0;
        ref_source_select[0] <= 2'h1;
        repeat (3) @(posedge pclk);
        loop_reset_n[0] <= 1'b1;
        wait_lock(8'h01);
        check(loop_locked[0], 1'b1);
        $display("test select done");
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, 8'h00, {29'h0, s[1:0], 1'b1});
            repeat (20) @(posedge pclk);
            count_ticks(1000);
            check(ticks >= (80 << s) - 3 && ticks <= (80 << s) + 3, 1'b1);
        end
        apb(1'b1, 8'h00, 32'h0);
        repeat (20) @(posedge pclk);
        count_ticks(1000);
        check(ticks, 32'h0);
        $display("test oscillator done");
        presetn <= 1'b0;
        loop_reset_n <= 8'h00;
        repeat (2) @(posedge pclk);
        check(pready, 1'b0);
        check(irq, 1'b0);
        check(loop_locked, 8'h00);
        presetn <= 1'b1;
        apb(1'b0, 8'h14, 32'h0);
        check(rdv, 32'h01041041);
        apb(1'b0, 8'h0C, 32'h0);
        check(rdv, 32'h0);
        check(loop_locked, 8'h00);
        $display("test reset done");
        print_verdict();
    end
endmodule : pcsc_top_bench
